// ==== bench/fsl_lamp_model.sv ====
// lamp observer: counts red flashes per burst and times green pulses
`timescale 1ns/10ps
module fsl_lamp_model #(
  parameter int GAP_MAX = 1000
) (
  input wire logic                   mclk,
  input wire fsl_pkg::fsl_lamp_out_t statusLamp,
  output logic [3:0]                 flashCnt,
  output logic                       burstDone,
  output int                         greenLen
);
  logic [3:0] cnt = 4'h0;
  logic       redQ = 1'b0;
  int         offCnt = 0;
  int         gOn = 0;
  initial {flashCnt, burstDone, greenLen} = '0;
  always @(posedge mclk) begin
    burstDone <= 1'b0;
    redQ <= statusLamp.red;
    if (statusLamp.red && !redQ) cnt <= cnt + 4'h1;
    offCnt <= statusLamp.red ? 0 : offCnt + 1;
    // a dark spell longer than any flash gap closes the burst
    if (offCnt == GAP_MAX && cnt != 4'h0) begin
      flashCnt <= cnt;
      cnt <= 4'h0;
      burstDone <= 1'b1;
    end
    gOn <= statusLamp.green ? gOn + 1 : 0;
    if (!statusLamp.green && gOn != 0) greenLen <= gOn;
  end
endmodule

// ==== bench/fsl_sva.sv ====
// checker: power, lamp and fault reset relations at the top ports
`timescale 1ns/10ps
module fsl_sva #(
  parameter int TICK_CYC = 4
) (
  input wire logic                  mclk,
  input wire logic                  sys_rst,
  input wire fsl_pkg::fsl_ahb_req_t ahbReq,
  input wire fsl_pkg::fsl_ahb_rsp_t ahbRsp,
  input wire logic [7:0]            tempC,
  input wire fsl_pkg::fsl_err_t     errIn,
  input wire logic                  powerEnable,
  input wire fsl_pkg::fsl_lamp_out_t statusLamp,
  input wire logic                  irq
);
  // one tick of slack: tick phase is not visible here
  localparam int GMAX = 101 * TICK_CYC;
  localparam int RMAX = 201 * TICK_CYC;
  localparam int PMIN = 1499 * TICK_CYC;
  logic        wPend;
  logic [7:0]  wAddr;
  logic        lampOffSh;
  logic [15:0] gCnt;
  logic [15:0] rCnt;
  logic [15:0] oCnt;
  logic        ctrlWr;
  logic        hot;
  assign ctrlWr = wPend && ahbReq.hready && (wAddr == fsl_pkg::REG_CTRL);
  assign hot    = tempC > fsl_pkg::OVERTEMP_C;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wPend <= 1'b0;
      wAddr <= 8'h00;
      lampOffSh <= 1'b0;
      gCnt <= 16'h0000;
      rCnt <= 16'h0000;
      oCnt <= 16'h0000;
    end else begin
      if (ahbReq.hready) begin
        wPend <= ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hwrite;
        wAddr <= ahbReq.haddr[7:0];
      end
      if (ctrlWr) lampOffSh <= ahbReq.hwdata[0];
      gCnt <= statusLamp.green ? gCnt + 16'h0001 : 16'h0000;
      rCnt <= statusLamp.red ? rCnt + 16'h0001 : 16'h0000;
      // saturate so a long idle never wraps into a legal gap
      oCnt <= statusLamp.red ? 16'h0000 : (oCnt == 16'hFFFF ? oCnt : oCnt + 16'h0001);
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_ot_power; $rose(hot) |=> !powerEnable; endproperty
  a_ot_power: assert property (p_ot_power) else $error("power on after overtemp");
  property p_ot_red; $rose(hot) && powerEnable && !lampOffSh |=> statusLamp.red && !statusLamp.green; endproperty
  a_ot_red: assert property (p_ot_red) else $error("lamp not red on error");
  property p_red_err; $rose(statusLamp.red) |-> !powerEnable; endproperty
  a_red_err: assert property (p_red_err) else $error("red with no error");
  property p_green_w; statusLamp.green |-> gCnt < GMAX; endproperty
  a_green_w: assert property (p_green_w) else $error("green pulse too long");
  property p_red_w; statusLamp.red |-> rCnt < RMAX && !statusLamp.green; endproperty
  a_red_w: assert property (p_red_w) else $error("red flash too long");
  property p_pause; $rose(statusLamp.red) && $past(!powerEnable) |-> oCnt < RMAX || oCnt > PMIN; endproperty
  a_pause: assert property (p_pause) else $error("bad red spacing");
  // the design takes the control word one edge before ctrlWr is seen here
  property p_reset; $rose(powerEnable) |-> (ctrlWr || $past(ctrlWr, 1)) && !$past(hot); endproperty
  a_reset: assert property (p_reset) else $error("power back without fault reset");
  property p_lamp_off; lampOffSh && $past(lampOffSh, 2) && !ctrlWr |-> statusLamp == 2'b00; endproperty
  a_lamp_off: assert property (p_lamp_off) else $error("lamp lit while off");
  c_red: cover property ($rose(statusLamp.red));
  c_clear: cover property ($rose(powerEnable));
  c_dark: cover property (lampOffSh && errIn.req);
endmodule

bind fsl_top fsl_sva #(.TICK_CYC(TICK_CYC)) u_fsl_sva (.mclk(mclk), .sys_rst(sys_rst),
  .ahbReq(ahbReq), .ahbRsp(ahbRsp), .tempC(tempC), .errIn(errIn),
  .powerEnable(powerEnable), .statusLamp(statusLamp), .irq(irq));

// ==== bench/tb_top.sv ====
// testbench: bus tasks and fault, lamp and history scenarios
`timescale 1ns/10ps
module tb_top;
  localparam int          T   = 4;
  localparam logic [15:0] OTD = 16'h0A5C; // arbitrary detail code
  logic                   mclk = 1'b0;
  logic                   sys_rst = 1'b1;
  fsl_pkg::fsl_ahb_req_t  req = '0;
  fsl_pkg::fsl_ahb_req_t  ahbReq;
  fsl_pkg::fsl_ahb_rsp_t  ahbRsp;
  logic [7:0]             tempC = 8'h19;
  fsl_pkg::fsl_err_t      errIn = '0;
  logic                   powerEnable;
  logic                   irq;
  fsl_pkg::fsl_lamp_out_t statusLamp;
  logic [3:0]             flashCnt;
  logic                   burstDone;
  int                     greenLen;
  int                     error_cnt = 0;
  int                     comparisons = 0;
  int                     cyc = 0;
  time                    t0;
  always_comb begin
    ahbReq = req;
    ahbReq.hready = ahbRsp.hreadyout;
  end
  fsl_top #(.HIST_DEPTH(8), .TICK_CYC(T), .OT_DETAIL(OTD)) u_fsl_top (.mclk(mclk),
    .sys_rst(sys_rst), .ahbReq(ahbReq), .ahbRsp(ahbRsp), .tempC(tempC), .errIn(errIn),
    .powerEnable(powerEnable), .statusLamp(statusLamp), .irq(irq));
  fsl_lamp_model #(.GAP_MAX(250 * T)) u_fsl_lamp_model (.mclk(mclk), .statusLamp(statusLamp),
    .flashCnt(flashCnt), .burstDone(burstDone), .greenLen(greenLen));
  initial begin
    forever #10 mclk = ~mclk;
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // hready is our own hreadyout, so both phases wait on it
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    req.hsel <= 1'b1;
    req.htrans <= fsl_pkg::HTRANS_NONSEQ;
    req.haddr <= {24'h00_0000, a};
    req.hwrite <= wr;
    req.hsize <= 3'h2;
    do @(posedge mclk); while (ahbRsp.hreadyout !== 1'b1);
    req.htrans <= 2'h0;
    req.hsel <= 1'b0;
    req.hwdata <= wd;
    do @(posedge mclk); while (ahbRsp.hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(ahbRsp.hrdata, exp);
    chk(ahbRsp.hresp, 1'b0);
  endtask
  task automatic pulse(input logic [2:0] c, input logic [15:0] code);
    errIn <= '{1'b1, c, code};
    @(posedge mclk);
    errIn.req <= 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    @(negedge statusLamp.green);
    t0 = $time;
    @(posedge statusLamp.green);
    chk(greenLen >= 99 * T && greenLen <= 101 * T, 1);
    chk(($time - t0) / 20 >= 899 * T && ($time - t0) / 20 <= 901 * T, 1);
    @(posedge mclk);
    rd(fsl_pkg::REG_STATE, 32'h0000_0002);
    rd(8'h1C, 32'h0000_0000);
    $display("test normal done");
    xfer(1'b1, fsl_pkg::REG_IRQ_MASK, 32'h0000_0007);
    tempC <= 8'h4C;
    repeat (2) @(posedge mclk);
    chk(powerEnable, 1'b0);
    chk(irq, 1'b1);
    @(posedge burstDone);
    chk(flashCnt, fsl_pkg::ERR_TEMP);
    rd(fsl_pkg::REG_STATE, 32'h0000_002D);
    rd(fsl_pkg::REG_IRQ_STAT, 32'h0000_0001);
    rd(fsl_pkg::REG_IRQ_STAT, 32'h0000_0000);
    chk(irq, 1'b0);
    rd(fsl_pkg::REG_HIST_CNT, 32'h0000_0001);
    xfer(1'b1, fsl_pkg::REG_HIST_IDX, 32'h0000_0000);
    rd(fsl_pkg::REG_HIST_DATA, {16'h0000, OTD});
    xfer(1'b1, fsl_pkg::REG_CTRL, 32'h0000_0002);
    repeat (4) @(posedge mclk);
    chk(powerEnable, 1'b0);
    rd(fsl_pkg::REG_IRQ_STAT, 32'h0000_0004);
    tempC <= 8'h46;
    xfer(1'b1, fsl_pkg::REG_CTRL, 32'h0000_0002);
    repeat (2) @(posedge mclk);
    chk(powerEnable, 1'b1);
    rd(fsl_pkg::REG_IRQ_STAT, 32'h0000_0002);
    $display("test overtemp done");
    for (int c = 1; c <= 6; c++) begin
      pulse(3'(c), 16'h0E00 + 16'(c));
      @(posedge burstDone);
      chk(flashCnt, 4'(c));
      xfer(1'b1, fsl_pkg::REG_HIST_IDX, 32'(c));
      rd(fsl_pkg::REG_HIST_DATA, 32'h0000_0E00 + 32'(c));
      xfer(1'b1, fsl_pkg::REG_CTRL, 32'h0000_0002);
    end
    rd(fsl_pkg::REG_HIST_CNT, 32'h0000_0007);
    $display("test classes done");
    xfer(1'b1, fsl_pkg::REG_CTRL, 32'h0000_0001);
    pulse(fsl_pkg::ERR_VOLTAGE, 16'h0E20);
    repeat (2000) @(posedge mclk);
    chk(statusLamp, 2'b00);
    rd(fsl_pkg::REG_CTRL, 32'h0000_0001);
    rd(fsl_pkg::REG_STATE, 32'h0000_0009);
    xfer(1'b1, fsl_pkg::REG_CTRL, 32'h0000_0003);
    xfer(1'b1, fsl_pkg::REG_CTRL, 32'h0000_0000);
    @(posedge statusLamp.green);
    chk(statusLamp.red, 1'b0);
    $display("test lamp off done");
    summarize();
  end
endmodule

// ==== rtl/fsl_hist_mem.sv ====
// small error history memory: one write port, registered read data
`timescale 1ns/10ps
module fsl_hist_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0]            rd;
  } fsl_mem_state_t;

  fsl_mem_state_t st_r;
  fsl_mem_state_t st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.rd = st_r.mem[rdAddr];
    if (wrEn) begin
      st_nxt.mem[wrAddr] = wrData;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdData = st_r.rd;
endmodule

// ==== rtl/fsl_pkg.sv ====
// package: constants, register map and state types of the fault and status lamp block
package fsl_pkg;
  // clock and lamp timing
  localparam int          CLK_HZ        = 50_000_000;
  localparam int          TICK_NS       = 1_000_000;
  localparam int          TICK_CYC      = (CLK_HZ / 1_000_000) * (TICK_NS / 1_000);
  localparam logic [10:0] GREEN_PER_MS  = 11'h03E8;
  localparam logic [10:0] GREEN_ON_MS   = 11'h0064;
  localparam logic [10:0] RED_ON_MS     = 11'h00C8;
  localparam logic [10:0] RED_GAP_MS    = 11'h00C8;
  localparam logic [10:0] RED_PAUSE_MS  = 11'h05DC;

  // overtemperature threshold in degrees Celsius
  localparam logic [7:0]  OVERTEMP_C    = 8'h4B;

  // error classes, value equals the flash count
  localparam logic [2:0]  ERR_GENERAL   = 3'h1;
  localparam logic [2:0]  ERR_VOLTAGE   = 3'h2;
  localparam logic [2:0]  ERR_TEMP      = 3'h3;
  localparam logic [2:0]  ERR_CURRENT   = 3'h4;
  localparam logic [2:0]  ERR_CTRL      = 3'h5;
  localparam logic [2:0]  ERR_WATCHDOG  = 3'h6;

  // register byte addresses
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_IRQ_STAT  = 8'h04;
  localparam logic [7:0]  REG_IRQ_MASK  = 8'h08;
  localparam logic [7:0]  REG_STATE     = 8'h0C;
  localparam logic [7:0]  REG_HIST_CNT  = 8'h10;
  localparam logic [7:0]  REG_HIST_IDX  = 8'h14;
  localparam logic [7:0]  REG_HIST_DATA = 8'h18;

  // field positions
  localparam int          CTRL_LAMP_OFF = 0;
  localparam int          CTRL_FRESET   = 1;
  localparam int          EV_ERROR      = 0;
  localparam int          EV_CLEARED    = 1;
  localparam int          EV_REFUSED    = 2;
  localparam int          EV_W          = 3;

  // AHB-Lite encodings
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ    = 2'h3;

  typedef enum logic [2:0] {
    LAMP_GREEN_ON,
    LAMP_GREEN_OFF,
    LAMP_RED_ON,
    LAMP_RED_GAP,
    LAMP_RED_PAUSE
  } fsl_lamp_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } fsl_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } fsl_ahb_rsp_t;

  typedef struct packed {
    logic        req;
    logic [2:0]  cls;
    logic [15:0] code;
  } fsl_err_t;

  typedef struct packed {
    logic        green;
    logic        red;
  } fsl_lamp_out_t;
endpackage

// ==== rtl/fsl_top.sv ====
// fault latch, power stage enable, two-colour status lamp and AHB-Lite register slave
`timescale 1ns/10ps
// Function
// - temperature above threshold disables power stage and sets the error flag
// - error clears only on fault reset command once temperature is back down
// - with no error, lamp pulses green briefly once every second
// - on error, lamp turns red and flashes in bursts showing the class
// - flash count: 1 general, 2 voltage, 3 temperature, 4 current, 5 control, 6 watchdog
// - every error event, except an errIn request in the same cycle as an overtemperature onset, stores its detailed code in the error history
// - a software setting turns the lamp fully off in all cases
module fsl_top #(
  parameter int          HIST_DEPTH = 8,
  parameter int          TICK_CYC   = fsl_pkg::TICK_CYC,
  parameter logic [15:0] OT_DETAIL  = 16'h4310
) (
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire fsl_pkg::fsl_ahb_req_t  ahbReq,
  output fsl_pkg::fsl_ahb_rsp_t       ahbRsp,
  input  wire logic [7:0]             tempC,
  input  wire fsl_pkg::fsl_err_t      errIn,
  output logic                        powerEnable,
  output fsl_pkg::fsl_lamp_out_t      statusLamp,
  output logic                        irq
);
  localparam int HAW = $clog2(HIST_DEPTH);

  typedef struct packed {
    logic [15:0]             divCnt;
    logic                    tick;
    logic                    errFlag;
    logic [2:0]              errClass;
    logic                    lampOff;
    logic [fsl_pkg::EV_W-1:0] irqStat;
    logic [fsl_pkg::EV_W-1:0] irqMask;
    logic [HAW:0]            histCnt;
    logic [HAW-1:0]          histWr;
    logic [HAW-1:0]          histIdx;
    fsl_pkg::fsl_lamp_t      lamp;
    logic [10:0]             msCnt;
    logic [2:0]              flashCnt;
    logic                    green;
    logic                    red;
    logic                    wrPend;
    logic [7:0]              wrAddr;
    logic [31:0]             rdata;
  } fsl_state_t;

  fsl_state_t     st_r;
  fsl_state_t     st_nxt;
  logic [15:0]    histRd;
  logic           hot;
  logic           evNew;
  logic [2:0]     evClass;
  logic [15:0]    evCode;
  logic           addrTake;
  logic [7:0]     aAddr;
  logic [31:0]    rdMux;
  logic           fresetCmd;

  // history written on the same edge as the event is latched in the state
  fsl_hist_mem #(
    .DEPTH (HIST_DEPTH),
    .WIDTH (16)
  ) u_hist (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .wrEn    (evNew),
    .wrAddr  (st_r.histWr),
    .wrData  (evCode),
    .rdAddr  (st_r.histIdx),
    .rdData  (histRd)
  );

  // an overtemperature that persists is one event, not one per cycle
  logic hotSeen_r;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hotSeen_r <= 1'b0;
    end else begin
      hotSeen_r <= hot;
    end
  end

  always_comb begin
    hot     = tempC > fsl_pkg::OVERTEMP_C;
    evNew   = 1'b0;
    evClass = fsl_pkg::ERR_GENERAL;
    evCode  = 16'h0000;
    if (hot && !hotSeen_r) begin
      evNew   = 1'b1;
      evClass = fsl_pkg::ERR_TEMP;
      evCode  = OT_DETAIL;
    end else if (errIn.req) begin
      evNew   = 1'b1;
      evClass = (errIn.cls >= fsl_pkg::ERR_GENERAL && errIn.cls <= fsl_pkg::ERR_WATCHDOG) ?
                errIn.cls : fsl_pkg::ERR_GENERAL;
      evCode  = errIn.code;
    end
  end

  // address phase and read mux
  always_comb begin
    addrTake = ahbReq.hsel && ahbReq.hready &&
               (ahbReq.htrans == fsl_pkg::HTRANS_NONSEQ ||
                ahbReq.htrans == fsl_pkg::HTRANS_SEQ);
    aAddr    = {ahbReq.haddr[7:2], 2'b00};
    unique case (aAddr)
      fsl_pkg::REG_CTRL:      rdMux = {31'h0000_0000, st_r.lampOff};
      fsl_pkg::REG_IRQ_STAT:  rdMux = {29'h0000_0000, st_r.irqStat};
      fsl_pkg::REG_IRQ_MASK:  rdMux = {29'h0000_0000, st_r.irqMask};
      fsl_pkg::REG_STATE:     rdMux = {24'h00_0000, 2'b00, hot, st_r.errClass,
                                       !st_r.errFlag, st_r.errFlag};
      fsl_pkg::REG_HIST_CNT:  rdMux = 32'(st_r.histCnt);
      fsl_pkg::REG_HIST_IDX:  rdMux = 32'(st_r.histIdx);
      fsl_pkg::REG_HIST_DATA: rdMux = {16'h0000, histRd};
      default:                rdMux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    st_nxt      = st_r;
    fresetCmd   = 1'b0;

    // one millisecond enable from the system clock
    st_nxt.tick = 1'b0;
    if (st_r.divCnt == 16'(TICK_CYC - 1)) begin
      st_nxt.divCnt = 16'h0000;
      st_nxt.tick   = 1'b1;
    end else begin
      st_nxt.divCnt = st_r.divCnt + 16'h0001;
    end

    // bus: reads answer with zero wait, writes take one wait state
    if (addrTake && !ahbReq.hwrite) begin
      st_nxt.rdata = rdMux;
      if (aAddr == fsl_pkg::REG_IRQ_STAT) begin
        st_nxt.irqStat = '0;
      end
    end
    st_nxt.wrPend = addrTake && ahbReq.hwrite;
    if (addrTake && ahbReq.hwrite) begin
      st_nxt.wrAddr = aAddr;
    end
    if (st_r.wrPend) begin
      unique case (st_r.wrAddr)
        fsl_pkg::REG_CTRL: begin
          st_nxt.lampOff = ahbReq.hwdata[fsl_pkg::CTRL_LAMP_OFF];
          fresetCmd      = ahbReq.hwdata[fsl_pkg::CTRL_FRESET];
        end
        fsl_pkg::REG_IRQ_MASK: st_nxt.irqMask = ahbReq.hwdata[fsl_pkg::EV_W-1:0];
        fsl_pkg::REG_HIST_IDX: st_nxt.histIdx = ahbReq.hwdata[HAW-1:0];
        default: ;
      endcase
    end

    // fault reset only accepted once cooled down
    if (fresetCmd && st_r.errFlag) begin
      if (hot) begin
        st_nxt.irqStat[fsl_pkg::EV_REFUSED] = 1'b1;
      end else begin
        st_nxt.errFlag                      = 1'b0;
        st_nxt.irqStat[fsl_pkg::EV_CLEARED] = 1'b1;
      end
    end

    // a new error wins over a same-cycle reset; first class is kept for the lamp
    if (evNew) begin
      st_nxt.errFlag                    = 1'b1;
      st_nxt.irqStat[fsl_pkg::EV_ERROR] = 1'b1;
      if (!st_r.errFlag) begin
        st_nxt.errClass = evClass;
      end
      st_nxt.histWr = st_r.histWr + HAW'(1);
      if (st_r.histCnt != (HAW+1)'(HIST_DEPTH)) begin
        st_nxt.histCnt = st_r.histCnt + (HAW+1)'(1);
      end
    end

    // lamp sequencer on the millisecond tick
    if (st_r.tick) begin
      st_nxt.msCnt = st_r.msCnt + 11'h001;
      unique case (st_r.lamp)
        fsl_pkg::LAMP_GREEN_ON: begin
          if (st_r.msCnt == fsl_pkg::GREEN_ON_MS - 11'h001) begin
            st_nxt.lamp = fsl_pkg::LAMP_GREEN_OFF;
          end
        end
        fsl_pkg::LAMP_GREEN_OFF: begin
          if (st_r.msCnt == fsl_pkg::GREEN_PER_MS - 11'h001) begin
            st_nxt.lamp  = fsl_pkg::LAMP_GREEN_ON;
            st_nxt.msCnt = 11'h000;
          end
        end
        fsl_pkg::LAMP_RED_ON: begin
          if (st_r.msCnt == fsl_pkg::RED_ON_MS - 11'h001) begin
            st_nxt.msCnt    = 11'h000;
            st_nxt.flashCnt = st_r.flashCnt + 3'h1;
            st_nxt.lamp     = (st_r.flashCnt + 3'h1 == st_r.errClass) ?
                              fsl_pkg::LAMP_RED_PAUSE : fsl_pkg::LAMP_RED_GAP;
          end
        end
        fsl_pkg::LAMP_RED_GAP: begin
          if (st_r.msCnt == fsl_pkg::RED_GAP_MS - 11'h001) begin
            st_nxt.msCnt = 11'h000;
            st_nxt.lamp  = fsl_pkg::LAMP_RED_ON;
          end
        end
        fsl_pkg::LAMP_RED_PAUSE: begin
          if (st_r.msCnt == fsl_pkg::RED_PAUSE_MS - 11'h001) begin
            st_nxt.msCnt    = 11'h000;
            st_nxt.flashCnt = 3'h0;
            st_nxt.lamp     = fsl_pkg::LAMP_RED_ON;
          end
        end
        default: st_nxt.lamp = fsl_pkg::LAMP_GREEN_ON;
      endcase
    end

    // colour change restarts the pattern so a red burst always begins with its first flash
    if (st_nxt.errFlag && !st_r.errFlag) begin
      st_nxt.lamp     = fsl_pkg::LAMP_RED_ON;
      st_nxt.msCnt    = 11'h000;
      st_nxt.flashCnt = 3'h0;
    end else if (!st_nxt.errFlag && st_r.errFlag) begin
      st_nxt.lamp  = fsl_pkg::LAMP_GREEN_ON;
      st_nxt.msCnt = 11'h000;
    end

    st_nxt.green = !st_nxt.lampOff && st_nxt.lamp == fsl_pkg::LAMP_GREEN_ON;
    st_nxt.red   = !st_nxt.lampOff && st_nxt.lamp == fsl_pkg::LAMP_RED_ON;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r      <= '0;
      st_r.lamp <= fsl_pkg::LAMP_GREEN_ON;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign powerEnable       = !st_r.errFlag;
  assign statusLamp.green  = st_r.green;
  assign statusLamp.red    = st_r.red;
  assign irq               = |(st_r.irqStat & st_r.irqMask);
  assign ahbRsp.hrdata     = st_r.rdata;
  assign ahbRsp.hreadyout  = !st_r.wrPend;
  assign ahbRsp.hresp      = 1'b0;
endmodule
